// [design/acc_pkg.sv]
// Package for the analog comparator control block: offsets, fields, reset values
package acc_pkg;
    localparam logic [3:0] ACC_OFS_CTRL = 4'h0;
    localparam logic [3:0] ACC_OFS_IRQ_STATUS = 4'h4;
    localparam logic [3:0] ACC_OFS_IRQ_MASK = 4'h8;
    localparam logic [3:0] ACC_OFS_POWER = 4'hC;
    localparam int ACC_BIT_ENABLE = 7;
    localparam int ACC_BIT_REFSEL = 6;
    localparam int ACC_BIT_FLAG = 5;
    localparam int ACC_BIT_IRQEN = 4;
    localparam int ACC_BIT_LEVEL = 3;
    localparam int ACC_BIT_PINEN = 2;
    localparam int ACC_BIT_POWER_STOP3 = 0;
    localparam int ACC_BIT_POWER_DEEP = 1;
    localparam logic [7:0] ACC_CTRL_RESET = 8'h00;
    localparam logic ACC_FLAG_RESET = 1'b0;
    localparam logic [1:0] ACC_STS_RESET = 2'h0;
    localparam logic [1:0] ACC_STS_WAKE = 2'h2;
    localparam logic [1:0] ACC_MASK_RESET = 2'h0;
    localparam logic [1:0] ACC_EDGE_FALL0 = 2'h0;
    localparam logic [1:0] ACC_EDGE_RISE = 2'h1;
    localparam logic [1:0] ACC_EDGE_FALL2 = 2'h2;
    localparam logic [1:0] ACC_EDGE_BOTH = 2'h3;
    // Output pin is not bonded out on this device
    localparam logic ACC_HAS_OUT_PIN = 1'b0;

    typedef struct packed {
        logic module_enable_bit;
        logic reference_select;
        logic compare_irq_enable;
        logic output_pin_enable;
        logic [1:0] event_edge_select;
    } acc_ctrl_s;

    localparam acc_ctrl_s ACC_CTRL_S_RESET = '{default: '0};
endpackage

// [design/acc_top.sv]
// Analog comparator control: register, event detection, interrupt, pin steering
`timescale 1ns/1ps
module acc_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic stop3_active,
    input wire logic deep_stop_wake,
    input wire logic comparator_raw_out,
    output logic analog_enable,
    output logic noninv_from_bandgap,
    output logic inverting_from_pin,
    output logic comparator_out_pin,
    output logic comparator_out_pin_oe,
    output logic irq
);
    acc_pkg::acc_ctrl_s ctrl_r;
    acc_pkg::acc_ctrl_s ctrl_nxt;
    logic flag_r;
    logic flag_nxt;
    logic [1:0] sts_r;
    logic [1:0] sts_nxt;
    logic [1:0] mask_r;
    logic [1:0] mask_nxt;
    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic stop3_s1_r;
    logic stop3_s2_r;
    logic wake_s1_r;
    logic wake_s2_r;
    logic wake_prev_r;

    function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
        case (sel)
            acc_pkg::ACC_EDGE_RISE: edge_hit = rise;
            acc_pkg::ACC_EDGE_BOTH: edge_hit = rise | fall;
            default: edge_hit = fall;
        endcase
    endfunction

    // Bus decode: one wait cycle, answer on the following edge
    wire logic access = avs_read | avs_write;
    wire logic wr_fire = avs_write & ack_r;
    wire logic rd_fire = avs_read & ack_r;
    wire logic wr_ctrl = wr_fire & (avs_address == acc_pkg::ACC_OFS_CTRL) & avs_byteenable[0];
    wire logic wr_sts = wr_fire & (avs_address == acc_pkg::ACC_OFS_IRQ_STATUS) & avs_byteenable[0];
    wire logic wr_mask = wr_fire & (avs_address == acc_pkg::ACC_OFS_IRQ_MASK) & avs_byteenable[0];
    wire logic [7:0] wd = avs_writedata[7:0];

    // Stop level 3 freezes all state but the bus handshake and the stop/wake synchronisers;
    // a deep-stop wake is an edge restoring reset values, even in stop, with status bit 1 set
    wire logic frozen = stop3_s2_r;
    wire logic wake_pulse = wake_s2_r & ~wake_prev_r;
    wire logic enabled = ctrl_r.module_enable_bit & ~frozen;
    wire logic level = enabled & sync2_r;
    wire logic rise = enabled & sync2_r & ~prev_r;
    wire logic fall = enabled & ~sync2_r & prev_r;
    wire logic event_hit = edge_hit(ctrl_r.event_edge_select, rise, fall);
    wire logic clr_flag = (wr_ctrl & wd[acc_pkg::ACC_BIT_FLAG]) | (wr_sts & wd[0]);
    wire logic [7:0] ctrl_byte = {ctrl_r.module_enable_bit, ctrl_r.reference_select, flag_r,
        ctrl_r.compare_irq_enable, level, ctrl_r.output_pin_enable, ctrl_r.event_edge_select};
    wire logic [31:0] rd_mux =
        (avs_address == acc_pkg::ACC_OFS_CTRL) ? {24'h000000, ctrl_byte} :
        (avs_address == acc_pkg::ACC_OFS_IRQ_STATUS) ? {30'h0, sts_r} :
        (avs_address == acc_pkg::ACC_OFS_IRQ_MASK) ? {30'h0, mask_r} :
        (avs_address == acc_pkg::ACC_OFS_POWER) ? {30'h0, wake_s2_r, stop3_s2_r} :
        32'h00000000;

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt.module_enable_bit = wd[acc_pkg::ACC_BIT_ENABLE];
            ctrl_nxt.reference_select = wd[acc_pkg::ACC_BIT_REFSEL];
            ctrl_nxt.compare_irq_enable = wd[acc_pkg::ACC_BIT_IRQEN];
            ctrl_nxt.output_pin_enable = acc_pkg::ACC_HAS_OUT_PIN & wd[acc_pkg::ACC_BIT_PINEN];
            ctrl_nxt.event_edge_select = wd[1:0];
        end
    end

    // Set beats clear when both land in one cycle
    assign flag_nxt = event_hit | (flag_r & ~clr_flag);
    assign sts_nxt[0] = event_hit | (sts_r[0] & ~(wr_sts & wd[0]));
    assign sts_nxt[1] = wake_pulse | (sts_r[1] & ~(wr_sts & wd[1]));
    assign mask_nxt = wr_mask ? wd[1:0] : mask_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stop3_s1_r <= 1'b0;
            stop3_s2_r <= 1'b0;
            wake_s1_r <= 1'b0;
            wake_s2_r <= 1'b0;
            wake_prev_r <= 1'b0;
        end else begin
            stop3_s1_r <= stop3_active;
            stop3_s2_r <= stop3_s1_r;
            wake_s1_r <= deep_stop_wake;
            wake_s2_r <= wake_s1_r;
            wake_prev_r <= wake_s2_r;
        end
    end

    // Comparator output is asynchronous to the bus clock
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
        end else if (!frozen) begin
            sync1_r <= comparator_raw_out;
            sync2_r <= sync1_r;
            prev_r <= sync2_r & ctrl_r.module_enable_bit;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= acc_pkg::ACC_CTRL_S_RESET;
        end else if (wake_pulse) begin
            ctrl_r <= acc_pkg::ACC_CTRL_S_RESET;
        end else if (!frozen) begin
            ctrl_r <= ctrl_nxt;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flag_r <= acc_pkg::ACC_FLAG_RESET;
        end else if (wake_pulse) begin
            flag_r <= acc_pkg::ACC_FLAG_RESET;
        end else if (!frozen) begin
            flag_r <= flag_nxt;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sts_r <= acc_pkg::ACC_STS_RESET;
        end else if (wake_pulse) begin
            sts_r <= acc_pkg::ACC_STS_WAKE;
        end else if (!frozen) begin
            sts_r <= sts_nxt;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mask_r <= acc_pkg::ACC_MASK_RESET;
        end else if (wake_pulse) begin
            mask_r <= acc_pkg::ACC_MASK_RESET;
        end else if (!frozen) begin
            mask_r <= mask_nxt;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h00000000;
        end else begin
            ack_r <= access & ~ack_r;
            rdata_r <= rd_fire ? rd_mux : rdata_r;
        end
    end

    // Read data must stand at the edge waitrequest is low, so it is driven combinationally there
    assign avs_readdata = ack_r ? rd_mux : rdata_r;
    assign avs_waitrequest = access & ~ack_r;

    assign analog_enable = enabled;
    assign noninv_from_bandgap = ctrl_r.reference_select;
    assign inverting_from_pin = 1'b1;
    assign comparator_out_pin = level & ctrl_r.output_pin_enable;
    assign comparator_out_pin_oe = ctrl_r.output_pin_enable;
    assign irq = (ctrl_r.compare_irq_enable & flag_r) | |(sts_r & mask_r);

    flag_sets_a: assert property (@(posedge ref_clk) disable iff (rst)
        (event_hit && !wake_pulse && !frozen) |=> flag_r)
        else $error("flag missed event");

    flag_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clr_flag && !event_hit && !frozen) |=> !flag_r)
        else $error("flag not cleared");

    irq_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
        (ctrl_r.compare_irq_enable && flag_r) |-> irq)
        else $error("irq missing");

    level_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        !ctrl_r.module_enable_bit |-> !ctrl_byte[acc_pkg::ACC_BIT_LEVEL])
        else $error("level not 0");

    pin_reserved_a: assert property (@(posedge ref_clk) disable iff (rst)
        !comparator_out_pin_oe)
        else $error("pin enable took a write");

    stop_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        (frozen && !wake_pulse) |=> $stable(ctrl_r) && $stable(flag_r))
        else $error("state moved in stop");

    wake_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
        wake_pulse |=> (ctrl_r == acc_pkg::ACC_CTRL_S_RESET) && !flag_r)
        else $error("wake no reset");

    sync_path_a: assert property (@(posedge ref_clk) disable iff (rst)
        enabled ##1 enabled[*2] |-> level == $past(comparator_raw_out, 2))
        else $error("sync depth wrong");

    rise_only_a: assert property (@(posedge ref_clk) disable iff (rst)
        (ctrl_r.event_edge_select == acc_pkg::ACC_EDGE_RISE && fall) |-> !event_hit)
        else $error("fall counted in rise mode");

    enable_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_ctrl && !frozen && !wake_pulse) |=> ctrl_r.module_enable_bit == $past(wd[acc_pkg::ACC_BIT_ENABLE]))
        else $error("enable bit not written");

    refsel_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_ctrl && !frozen && !wake_pulse) |=> noninv_from_bandgap == $past(wd[acc_pkg::ACC_BIT_REFSEL]))
        else $error("reference select not applied");

    irqen_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_ctrl && !frozen && !wake_pulse) |=> ctrl_r.compare_irq_enable == $past(wd[acc_pkg::ACC_BIT_IRQEN]))
        else $error("irq enable not written");

    mode_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_ctrl && !frozen && !wake_pulse) |=> ctrl_r.event_edge_select == $past(wd[1:0]))
        else $error("edge select not written");

    inv_pin_a: assert property (@(posedge ref_clk) disable iff (rst)
        inverting_from_pin)
        else $error("inverting input left its pin");

    flag_no_spur_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!flag_r && !event_hit) |=> !flag_r)
        else $error("flag set without event");

    flag_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
        (flag_r && !clr_flag && !wake_pulse) |=> flag_r)
        else $error("flag lost without clear");

    flag_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        (rd_fire && avs_address == acc_pkg::ACC_OFS_CTRL) |-> avs_readdata[acc_pkg::ACC_BIT_FLAG] == flag_r)
        else $error("flag read wrong");

    irq_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!ctrl_r.compare_irq_enable && (sts_r & mask_r) == 2'h0) |-> !irq)
        else $error("irq while disabled");

    irq_flag_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!flag_r && (sts_r & mask_r) == 2'h0) |-> !irq)
        else $error("irq without flag");

    irq_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
        ((sts_r & mask_r) != 2'h0) |-> irq)
        else $error("unmasked status gives no irq");

    level_track_a: assert property (@(posedge ref_clk) disable iff (rst)
        enabled |-> level == sync2_r)
        else $error("level not from synchroniser");

    level_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        (rd_fire && avs_address == acc_pkg::ACC_OFS_CTRL) |-> avs_readdata[acc_pkg::ACC_BIT_LEVEL] == level)
        else $error("level read wrong");

    level_dis_rd_a: assert property (@(posedge ref_clk) disable iff (rst)
        (rd_fire && avs_address == acc_pkg::ACC_OFS_CTRL && !ctrl_r.module_enable_bit)
        |-> !avs_readdata[acc_pkg::ACC_BIT_LEVEL]) else $error("level read while off");

    pin_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
        !comparator_out_pin_oe |-> !comparator_out_pin)
        else $error("pin driven while not enabled");

    pin_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        wr_ctrl |=> !ctrl_r.output_pin_enable)
        else $error("pin enable stored");

    pin_read_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
        (rd_fire && avs_address == acc_pkg::ACC_OFS_CTRL) |-> !avs_readdata[acc_pkg::ACC_BIT_PINEN])
        else $error("pin enable reads 1");

    fall_code_a: assert property (@(posedge ref_clk) disable iff (rst)
        (ctrl_r.event_edge_select != acc_pkg::ACC_EDGE_RISE && fall) |-> event_hit)
        else $error("falling edge missed");

    rise_code_a: assert property (@(posedge ref_clk) disable iff (rst)
        (ctrl_r.event_edge_select[0] && rise) |-> event_hit)
        else $error("rising edge missed");

    rise_ignored_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!ctrl_r.event_edge_select[0] && rise) |-> !event_hit)
        else $error("rise counted in fall mode");

    stop_no_event_a: assert property (@(posedge ref_clk) disable iff (rst)
        frozen |-> !event_hit)
        else $error("event seen in stop");

    stop_core_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        frozen |-> !analog_enable)
        else $error("core on in stop");

    stop_sync_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        frozen |=> $stable(sync2_r) && $stable(prev_r))
        else $error("synchroniser moved in stop");

    stop_regs_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        (frozen && !wake_pulse) |=> $stable(sts_r) && $stable(mask_r))
        else $error("status moved in stop");

    wake_status_a: assert property (@(posedge ref_clk) disable iff (rst)
        wake_pulse |=> (sts_r == acc_pkg::ACC_STS_WAKE) && (mask_r == acc_pkg::ACC_MASK_RESET))
        else $error("wake status wrong");

    wake_irq_a: assert property (@(posedge ref_clk) disable iff (rst)
        wake_pulse |=> !irq)
        else $error("irq after wake");

    sync_two_a: assert property (@(posedge ref_clk) disable iff (rst)
        !frozen |=> sync2_r == $past(sync1_r))
        else $error("second stage skipped");

    edge_needs_en_a: assert property (@(posedge ref_clk) disable iff (rst)
        !enabled |-> !rise && !fall)
        else $error("edge while disabled");
endmodule

// [tb/acc_cmp_model.sv]
// Behavioural analog comparator core with its two input pins
`timescale 1ns/1ps
module acc_cmp_model #(
    parameter int BANDGAP_MV = 1200
) (
    input wire logic analog_enable,
    input wire logic noninv_from_bandgap,
    input wire logic inverting_from_pin,
    input wire logic [11:0] pos_pin_mv,
    input wire logic [11:0] neg_pin_mv,
    output logic comparator_raw_out
);
    logic [11:0] noninv_mv;
    logic [11:0] inv_mv;
    assign noninv_mv = noninv_from_bandgap ? 12'(BANDGAP_MV) : pos_pin_mv;
    assign inv_mv = inverting_from_pin ? neg_pin_mv : 12'h000;
    // Powered-down core rests low, so stop levels show no activity
    assign comparator_raw_out = analog_enable & (noninv_mv > inv_mv);
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h1;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, stop3_active = 1'b0, deep_stop_wake = 1'b0, comparator_raw_out;
    logic analog_enable, noninv_from_bandgap, inverting_from_pin, comparator_out_pin, comparator_out_pin_oe, irq;
    logic [11:0] v_pos = 12'h1F4;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    acc_top DUT (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .stop3_active, .deep_stop_wake, .comparator_raw_out, .analog_enable,
        .noninv_from_bandgap, .inverting_from_pin, .comparator_out_pin, .comparator_out_pin_oe, .irq);
    acc_cmp_model core (.analog_enable, .noninv_from_bandgap, .inverting_from_pin, .pos_pin_mv(v_pos),
        .neg_pin_mv(12'h3E8), .comparator_raw_out);
    always #50 ref_clk = ~ref_clk;
    task automatic test_done();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Holds the request until waitrequest is seen low, then lets one edge settle
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q & {24'h0, m}, {24'h0, e});
    endtask
    task automatic setp(input logic [11:0] mv);
        @(posedge ref_clk);
        v_pos <= mv;
        ticks(5);
    endtask
    task automatic t_reset();
        rdchk(4'h0, 8'hFF, 8'h00);
        rdchk(4'h2, 8'hFF, 8'h00);
        chk(inverting_from_pin, 1'b1);
    endtask
    task automatic t_level();
        wr(4'h0, 8'h80);
        setp(12'h5DC);
        rdchk(4'h0, 8'h08, 8'h08);
        chk(analog_enable, 1'b1);
        setp(12'h1F4);
        rdchk(4'h0, 8'h08, 8'h00);
        wr(4'h0, 8'hC0);
        ticks(4);
        chk(noninv_from_bandgap, 1'b1);
        rdchk(4'h0, 8'h08, 8'h08);
        wr(4'h0, 8'hC4);
        rdchk(4'h0, 8'h04, 8'h00);
        chk(comparator_out_pin_oe, 1'b0);
        chk(comparator_out_pin, 1'b0);
        wr(4'h0, 8'h00);
        rdchk(4'h0, 8'h08, 8'h00);
        chk(analog_enable, 1'b0);
    endtask
    task automatic t_edges();
        for (int m = 0; m < 4; m++) begin
            wr(4'h0, 8'h80 | 8'(m));
            wr(4'h0, 8'hA0 | 8'(m));
            setp(12'h5DC);
            rdchk(4'h0, 8'h20, (m % 2 == 1) ? 8'h20 : 8'h00);
            wr(4'h0, 8'hA0 | 8'(m));
            setp(12'h1F4);
            rdchk(4'h0, 8'h20, (m != 1) ? 8'h20 : 8'h00);
            wr(4'h0, 8'hA0 | 8'(m));
        end
    endtask
    task automatic t_irq();
        wr(4'h0, 8'h91);
        wr(4'h4, 8'h03);
        wr(4'h8, 8'h00);
        setp(12'h5DC);
        chk(irq, 1'b1);
        wr(4'h0, 8'h81);
        rdchk(4'h0, 8'h20, 8'h20);
        chk(irq, 1'b0);
        wr(4'h8, 8'h01);
        chk(irq, 1'b1);
        wr(4'h4, 8'h01);
        rdchk(4'h4, 8'h01, 8'h00);
        chk(irq, 1'b0);
        wr(4'h0, 8'hA1);
        rdchk(4'h0, 8'h20, 8'h00);
    endtask
    task automatic t_stop();
        setp(12'h1F4);
        wr(4'h0, 8'hA3);
        stop3_active <= 1'b1;
        ticks(4);
        chk(analog_enable, 1'b0);
        setp(12'h5DC);
        setp(12'h1F4);
        stop3_active <= 1'b0;
        ticks(4);
        rdchk(4'h0, 8'hF7, 8'h83);
        deep_stop_wake <= 1'b1;
        ticks(3);
        deep_stop_wake <= 1'b0;
        ticks(5);
        rdchk(4'h0, 8'hFF, 8'h00);
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_level();
        t_edges();
        t_irq();
        t_stop();
        test_done();
    end
endmodule
